/* core/flash_id_readout.v */
`timescale 1ns/10ps
`include "flash_id_map.vh"
module flash_id_readout (
    // clock and reset
    input wire clk_sys,
    input wire rst_b,
    // serial link pins
    input wire chipSel_b,
    input wire serClk,
    input wire serIn,
    output reg serOut_q,
    output reg serOutEn_q,
    // state from the rest of the command decoder
    input wire write_in_progress_flag,
    input wire deepSleep,
    // factory state views
    output reg [7:0] statusReg_q,
    output reg [7:0] arrayErased_q
);
    localparam ST_IDLE = 3'd0;
    localparam ST_CMD = 3'd1;
    localparam ST_ADDR = 3'd2;
    localparam ST_ID_OUT = 3'd3;
    localparam ST_UID_OUT = 3'd4;
    localparam ST_IGNORE = 3'd5;

    // synchronised pin views; vector order is select, link clock, data
    localparam [2:0] PIN_IDLE = `PIN_IDLE_LEVELS;
    wire [2:0] pinRaw;
    wire [2:0] pinLevel;
    wire [2:0] pinRise;
    wire [2:0] pinFall;
    wire selLevel;
    wire selRise;
    wire clkRise;
    wire clkFall;
    wire dataLevel;

    // input phase decisions
    wire [7:0] cmdNext;
    wire cmdDone;
    wire addrDone;

    // output phase bookkeeping
    wire outPhase;
    wire outPhaseNext;
    wire idExhausted;
    wire uidExhausted;
    wire outBit;

    reg [2:0] state_q;
    reg [2:0] state_d;
    reg [7:0] cmdShift_q;
    reg [5:0] inCount_q;
    reg [7:0] outCount_q;
    reg [127:0] outShift_q;
    reg wipLatch_q;
    reg sleepLatch_q;

    // link pins cross into clk_sys through two flops each
    assign pinRaw = {serIn, serClk, chipSel_b};
    genvar pinIdx;
    generate
        for (pinIdx = 0; pinIdx < 3; pinIdx = pinIdx + 1) begin : gSync
            sync_edge #(
                .IDLE_LEVEL(PIN_IDLE[pinIdx])
            ) syncPin (
                .clk_sys(clk_sys),
                .rst_b(rst_b),
                .pinIn(pinRaw[pinIdx]),
                .level_q(pinLevel[pinIdx]),
                .rise(pinRise[pinIdx]),
                .fall(pinFall[pinIdx])
            );
        end
    endgenerate

    // the select level alone opens a frame, so its fall is not used
    assign selLevel = pinLevel[0];
    assign selRise = pinRise[0];
    assign clkRise = pinRise[1];
    assign clkFall = pinFall[1];
    assign dataLevel = pinLevel[2];

    // decode a finished command byte into the next state; sleep and busy
    // are checked first so no code can slip past them
    function [2:0] decodeCmd;
        input [7:0] code;
        input busy;
        input sleeping;
        begin
            decodeCmd = ST_IGNORE;
            if (sleeping) begin
                decodeCmd = ST_IGNORE;
            end else if (busy) begin
                decodeCmd = ST_IGNORE;
            end else begin
                case (code)
                    `CMD_READ_IDENTITY: begin
                        decodeCmd = ST_ID_OUT;
                    end
                    `CMD_READ_UNIQUE: begin
                        decodeCmd = ST_ADDR;
                    end
                    default: begin
                        // other codes belong to the rest of the decoder
                        decodeCmd = ST_IGNORE;
                    end
                endcase
            end
        end
    endfunction

    // true in the two states that drive the output pin
    function isOutState;
        input [2:0] st;
        begin
            isOutState = (st == ST_ID_OUT) || (st == ST_UID_OUT);
        end
    endfunction

    // next command byte and the end of each input phase
    assign cmdNext = {cmdShift_q[6:0], dataLevel};
    assign cmdDone = (state_q == ST_CMD) && clkRise
        && (inCount_q == `CMD_BITS - 6'd1);
    assign addrDone = (state_q == ST_ADDR) && clkRise
        && (inCount_q == `UID_ADDR_DUMMY_BITS - 6'd1);

    // output phase views; the saturating counter keeps a long readout
    // from ever wrapping back into data
    assign outPhase = isOutState(state_q);
    assign outPhaseNext = isOutState(state_d);
    assign idExhausted = (state_q == ST_ID_OUT) && (outCount_q >= `ID_BITS);
    assign uidExhausted = (state_q == ST_UID_OUT) && (outCount_q >= `UID_BITS);
    assign outBit = (idExhausted || uidExhausted) ? 1'b0 : outShift_q[127];

    // next-state logic; deselect always wins
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (!selLevel) begin
                    state_d = ST_CMD;
                end
            end
            ST_CMD: begin
                if (cmdDone) begin
                    state_d = decodeCmd(cmdNext, wipLatch_q, sleepLatch_q);
                end
            end
            ST_ADDR: begin
                if (addrDone) begin
                    state_d = ST_UID_OUT;
                end
            end
            ST_ID_OUT: begin
                // held until deselect; bits past the value read as zero
                state_d = ST_ID_OUT;
            end
            ST_UID_OUT: begin
                // the unique number runs until deselect
                state_d = ST_UID_OUT;
            end
            ST_IGNORE: begin
                // refused or unknown command: the pin stays released
                state_d = ST_IGNORE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        if (selRise || selLevel) begin
            state_d = ST_IDLE;
        end
    end

    // state register and the decision latches
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            state_q <= ST_IDLE;
            wipLatch_q <= 1'b0;
            sleepLatch_q <= 1'b0;
        end else begin
            state_q <= state_d;
            // registered so the decode sees a steady level
            wipLatch_q <= write_in_progress_flag;
            sleepLatch_q <= deepSleep;
        end
    end

    // input shifter for command, address and dummy bits
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            cmdShift_q <= 8'h00;
        end else if ((state_q == ST_CMD || state_q == ST_ADDR) && clkRise) begin
            cmdShift_q <= cmdNext;
        end
    end

    // input bit counter, cleared between phases and frames
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            inCount_q <= 6'd0;
        end else if (state_q == ST_IDLE) begin
            inCount_q <= 6'd0;
        end else if ((state_q == ST_CMD || state_q == ST_ADDR) && clkRise) begin
            inCount_q <= (cmdDone || addrDone) ? 6'd0 : inCount_q + 6'd1;
        end
    end

    // output shifter, loaded as the input phase closes, msb at top
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            outShift_q <= 128'h0;
        end else if (cmdDone && state_d == ST_ID_OUT) begin
            outShift_q <= {`ID_MAKER, `ID_MEM_TYPE, `ID_CAPACITY, 104'h0};
        end else if (addrDone) begin
            outShift_q <= `UNIQUE_ID_VALUE;
        end else if (outPhase && clkFall) begin
            outShift_q <= {outShift_q[126:0], 1'b0};
        end
    end

    // count of bits driven in this output phase, held at its top value
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            outCount_q <= 8'd0;
        end else if (!outPhase) begin
            outCount_q <= 8'd0;
        end else if (clkFall && outCount_q != `OUT_COUNT_MAX) begin
            outCount_q <= outCount_q + 8'd1;
        end
    end

    // pin driver: change data on falling link clock, or clear it on release; the enable
    // follows the next state so a deselect releases the pin a cycle sooner
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            serOut_q <= 1'b0;
            serOutEn_q <= 1'b0;
        end else if (!outPhaseNext) begin
            serOutEn_q <= 1'b0;
            serOut_q <= 1'b0;
        end else if (clkFall) begin
            // bits past the end of the value read as zero
            serOutEn_q <= 1'b1;
            serOut_q <= outBit;
        end
    end

    // factory state views, fixed after reset
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            statusReg_q <= `STATUS_RESET;
            arrayErased_q <= `ARRAY_ERASED_BYTE;
        end else begin
            statusReg_q <= statusReg_q;
            arrayErased_q <= arrayErased_q;
        end
    end
endmodule

/* core/sync_edge.v */
`timescale 1ns/10ps
// two-flop synchroniser plus edge finder on the second stage only
module sync_edge #(
    parameter IDLE_LEVEL = 1'b0
) (
    // clock and reset
    input wire clk_sys,
    input wire rst_b,
    // raw pin and results
    input wire pinIn,
    output reg level_q,
    output wire rise,
    output wire fall
);
    reg meta_q;
    reg prev_q;
    // first flop feeds only the second flop; reset to the idle level of
    // the pin, so no false edge follows reset
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            meta_q <= IDLE_LEVEL;
            level_q <= IDLE_LEVEL;
            prev_q <= IDLE_LEVEL;
        end else begin
            meta_q <= pinIn;
            level_q <= meta_q;
            prev_q <= level_q;
        end
    end
    assign rise = level_q & ~prev_q;
    assign fall = ~level_q & prev_q;
endmodule

/* pkg/flash_id_map.vh */
`ifndef FLASH_ID_MAP_VH
`define FLASH_ID_MAP_VH
// command codes
`define CMD_READ_IDENTITY 8'h9F
`define CMD_READ_UNIQUE 8'h4B
`define CMD_RELEASE_SLEEP 8'hAB
// identity bytes (arbitrary neutral values)
`define ID_MAKER 8'h5A
`define ID_MEM_TYPE 8'h40
`define ID_CAPACITY 8'h11
// unique number, arbitrary neutral value
`define UNIQUE_ID_VALUE 128'h0123456789ABCDEF0F1E2D3C4B5A6978
// phase lengths in link bits
`define CMD_BITS 6'd8
`define UID_ADDR_DUMMY_BITS 6'd32
`define ID_BITS 8'd24
`define UID_BITS 8'd128
// synchroniser reset levels, select idles high, clock and data low
`define PIN_IDLE_LEVELS 3'h1
// output bit counter holds at this value
`define OUT_COUNT_MAX 8'hFF
// factory state
`define ARRAY_ERASED_BYTE 8'hFF
`define STATUS_RESET 8'h00
`endif

/* sim/flash_id_readout_sva.sv */
`timescale 1ns/10ps
`include "flash_id_map.vh"
module flash_id_readout_sva (
    // clock and reset
    input wire clk_sys,
    input wire rst_b,
    // link pins
    input wire chipSel_b,
    input wire serClk,
    input wire serIn,
    input wire serOut_q,
    input wire serOutEn_q,
    // decoder state, factory views
    input wire write_in_progress_flag,
    input wire deepSleep,
    input wire [7:0] statusReg_q,
    input wire [7:0] arrayErased_q
);
    // single domain
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    property p_sts; statusReg_q == `STATUS_RESET; endproperty
    a_sts: assert property (p_sts) else $error("status bad");
    property p_arr; arrayErased_q == `ARRAY_ERASED_BYTE; endproperty
    a_arr: assert property (p_arr) else $error("array bad");
    property p_low; !serOutEn_q |-> !serOut_q; endproperty
    a_low: assert property (p_low) else $error("idle out");
    property p_off; chipSel_b [*5] |-> !serOutEn_q; endproperty
    a_off: assert property (p_off) else $error("late stop");
    property p_busy; $rose(serOutEn_q) |-> !$past(write_in_progress_flag, 4); endproperty
    a_busy: assert property (p_busy) else $error("busy out");
    property p_slp; $rose(serOutEn_q) |-> !$past(deepSleep, 4); endproperty
    a_slp: assert property (p_slp) else $error("sleep out");
    // output may only move once the link clock has been low a while
    property p_fall; $changed(serOut_q) && $past(serOutEn_q) |-> !$past(serClk, 2); endproperty
    a_fall: assert property (p_fall) else $error("bad edge");
    property p_sel; $rose(serOutEn_q) |-> !$past(chipSel_b) && !$past(chipSel_b, 2); endproperty
    a_sel: assert property (p_sel) else $error("unselected");
    c_on: cover property ($rose(serOutEn_q));
    c_cut: cover property ($fell(serOutEn_q));
    c_busy: cover property (write_in_progress_flag && !chipSel_b);
endmodule
bind flash_id_readout flash_id_readout_sva chk_u (.*);

/* sim/spi_host_model.sv */
`timescale 1ns/10ps
module spi_host_model (
    // host driven pins
    output logic chipSel_b,
    output logic serClk,
    output logic serIn,
    // device answer
    input wire serOut_q,
    input wire serOutEn_q
);
    // deselected, link clock parked low
    initial begin
        chipSel_b = 1'b1;
        serClk = 1'b0;
        serIn = 1'b0;
    end
    // 13 ns offset keeps link edges off clk_sys edges
    task automatic xfer(input logic [39:0] tx, input int nIn, input int nOut,
        output logic [127:0] rx);
        rx = '0;
        #13 chipSel_b = 1'b0;
        for (int i = 0; i < nIn + nOut; i++) begin
            serIn = (i < nIn) ? tx[39 - i] : ~serIn;
            #160 serClk = 1'b1;
            #160 if (i >= nIn) rx = {rx[126:0], serOutEn_q ? serOut_q : 1'bz};
            serClk = 1'b0;
        end
        #160 chipSel_b = 1'b1;
        serIn = ~serIn; // released line must not look stable
        #400;
    endtask
endmodule

/* sim/testbench.sv */
`timescale 1ns/10ps
`include "flash_id_map.vh"
module testbench;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic write_in_progress_flag = 1'b0;
    logic deepSleep = 1'b0;
    wire chipSel_b, serClk, serIn, serOut_q, serOutEn_q;
    wire [7:0] statusReg_q, arrayErased_q;
    logic [127:0] rx;
    int n_mismatch = 0;
    int checks = 0;
    int n;
    flash_id_readout dut_u (.*);
    spi_host_model host_u (.*);
    // 25 MHz
    initial forever #20 clk_sys = ~clk_sys;
    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict;
        $display("mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // top n identity bits, msb first
    function automatic logic [127:0] idw(input int n);
        return 128'({`ID_MAKER, `ID_MEM_TYPE, `ID_CAPACITY} >> (24 - n));
    endfunction
    // n released output slots
    function automatic logic [127:0] zs(input int n);
        zs = '0;
        for (int i = 0; i < n; i++) zs[i] = 1'bz;
    endfunction
    // command, zero address, random dummy, readout
    task automatic run(input logic [7:0] c, input int nPad, input int nOut, input logic [127:0] e);
        host_u.xfer({c, 24'h000000, 8'($urandom)}, 8 + nPad, nOut, rx);
        check(rx, e);
    endtask
    // watchdog, well past the ~0.7 ms run
    initial begin
        #2000000;
        n_mismatch++;
        give_verdict;
    end
    initial begin
        void'($urandom(53239));
        repeat (5) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk_sys);
        check(128'({statusReg_q, arrayErased_q}), 128'({`STATUS_RESET, `ARRAY_ERASED_BYTE}));
        for (int k = 0; k < 6; k++) begin
            n = (k == 0) ? 1 : 1 + $urandom % 23;
            run(`CMD_READ_IDENTITY, 0, 24, idw(24));
            run(`CMD_READ_IDENTITY, 0, n, idw(n));
            run(`CMD_READ_UNIQUE, 32, 128, `UNIQUE_ID_VALUE);
            run({2'b00, 6'($urandom)}, 0, 16, zs(16));
            @(posedge clk_sys) write_in_progress_flag <= 1'b1;
            run(`CMD_READ_IDENTITY, 0, 24, zs(24));
            @(posedge clk_sys) {write_in_progress_flag, deepSleep} <= 2'b01;
            run(`CMD_READ_UNIQUE, 32, 24, zs(24));
            @(posedge clk_sys) deepSleep <= 1'b0;
        end
        give_verdict;
    end
endmodule
